/* File: core/gpio_def_pkg.sv */
/*
 * Shared constants for the port D/E/F general-purpose I/O block:
 * register offsets, reset values, host control field positions,
 * pin positions of the multiplexed functions and bus widths.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package gpio_def_pkg;
  // ********************************************************
  // Widths
  // ********************************************************
  localparam int unsigned ADDR_W  = 5;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned BE_W    = 4;
  localparam int unsigned DPORT_W = 8;
  localparam int unsigned EPORT_W = 8;
  localparam int unsigned FPORT_W = 4;
  localparam int unsigned CTRL_W  = 9;
  localparam int unsigned PULL_W  = 6;
  localparam int unsigned LAD_W   = 4;

  // ********************************************************
  // Register byte offsets
  // ********************************************************
  localparam logic [ADDR_W-1:0] OFS_DPORT_PIN_DIR  = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_DPORT_OUT_DATA = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_EPORT_PIN_DIR  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_EPORT_OUT_DATA = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_FPORT_PIN_DIR  = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_FPORT_OUT_DATA = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_HOST_IF_CTRL   = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_PULLUP_STATE   = 5'h1C;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [DPORT_W-1:0] DPORT_RST  = 8'h00;
  localparam logic [EPORT_W-1:0] EPORT_RST  = 8'h00;
  localparam logic [FPORT_W-1:0] FPORT_RST  = 4'h0;
  localparam logic [CTRL_W-1:0]  CTRL_RST   = 9'h000;
  localparam logic [PULL_W-1:0]  PULL_RST   = 6'h00;
  localparam logic [DATA_W-1:0]  RDATA_ZERO = 32'h0000_0000;

  // ********************************************************
  // Host control register fields
  // ********************************************************
  localparam int unsigned CB_CH1   = 0;
  localparam int unsigned CB_CH2   = 1;
  localparam int unsigned CB_CH3   = 2;
  localparam int unsigned CB_SFIFO = 3;
  localparam int unsigned CB_TW5   = 4;
  localparam int unsigned CB_A20   = 5;
  localparam int unsigned CB_PME   = 6;
  localparam int unsigned CB_SMI   = 7;
  localparam int unsigned CB_SCI   = 8;

  // ********************************************************
  // Pin positions of shared functions
  // ********************************************************
  localparam int unsigned DP_TW_DATA = 7;
  localparam int unsigned DP_TW_CLK  = 6;
  localparam int unsigned DP_PWRDN   = 5;
  localparam int unsigned DP_CLOCK_RUN_LINE  = 4;
  localparam int unsigned DP_A20     = 3;
  localparam int unsigned DP_PME     = 2;
  localparam int unsigned DP_SMI     = 1;
  localparam int unsigned DP_SCI     = 0;
  localparam int unsigned EP_SERIRQ  = 7;
  localparam int unsigned EP_LCLK    = 6;
  localparam int unsigned EP_LRST    = 5;
  localparam int unsigned EP_FRAME   = 4;
  localparam int unsigned EP_LAD_HI  = 3;
endpackage

/* File: core/gpio_def_pkg_note.sv */
/*
 * Intentionally empty compile unit kept out of the design list.
 */

/* File: core/gpio_def_port.sv */
/*
 * GPIO ports D (8 pins), E (8 pins) and F (4 pins) with peripheral
 * pin multiplexing, port D pull-up control and an Avalon-MM slave.
 * Assumes pins are asynchronous to i_clk, peripheral signals come from
 * on-chip units on the same clock, and i_wdt_rst is a synchronous level.
 */
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module gpio_def_port
  import gpio_def_pkg::*;
(
  // Clock and resets
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_wdt_rst,
  // Power modes
  input  wire logic                         i_hw_standby,
  input  wire logic                         i_sw_standby,
  // Avalon-MM slave
  input  wire logic [gpio_def_pkg::ADDR_W-1:0]  i_address,
  input  wire logic                         i_read,
  input  wire logic                         i_write,
  input  wire logic [gpio_def_pkg::DATA_W-1:0]  i_writedata,
  input  wire logic [gpio_def_pkg::BE_W-1:0]    i_byteenable,
  output logic      [gpio_def_pkg::DATA_W-1:0]  o_readdata,
  output logic                              o_waitrequest,
  // Pad levels
  input  wire logic [gpio_def_pkg::DPORT_W-1:0] i_dport_pin,
  input  wire logic [gpio_def_pkg::EPORT_W-1:0] i_eport_pin,
  input  wire logic [gpio_def_pkg::FPORT_W-1:0] i_fport_pin,
  // Pad drive
  output logic      [gpio_def_pkg::DPORT_W-1:0] o_dport_out,
  output logic      [gpio_def_pkg::DPORT_W-1:0] o_dport_oe,
  output logic      [gpio_def_pkg::PULL_W-1:0]  o_dport_pullup,
  output logic      [gpio_def_pkg::EPORT_W-1:0] o_eport_out,
  output logic      [gpio_def_pkg::EPORT_W-1:0] o_eport_oe,
  output logic      [gpio_def_pkg::FPORT_W-1:0] o_fport_out,
  output logic      [gpio_def_pkg::FPORT_W-1:0] o_fport_oe,
  // Peripheral drive requests
  input  wire logic                         i_tw5_data_oe,
  input  wire logic                         i_tw5_data_out,
  input  wire logic                         i_tw5_clk_oe,
  input  wire logic                         i_tw5_clk_out,
  input  wire logic                         i_clock_run_oe,
  input  wire logic                         i_clock_run_out,
  input  wire logic                         i_gate_a20_out,
  input  wire logic                         i_power_event_out,
  input  wire logic                         i_sys_mgmt_irq_out,
  input  wire logic                         i_ctrl_irq_out,
  input  wire logic                         i_serirq_oe,
  input  wire logic                         i_serirq_out,
  input  wire logic [gpio_def_pkg::LAD_W-1:0]   i_lad_oe,
  input  wire logic [gpio_def_pkg::LAD_W-1:0]   i_lad_out,
  // Pin levels and enables for peripherals
  output logic      [gpio_def_pkg::DPORT_W-1:0] o_dport_level,
  output logic      [gpio_def_pkg::EPORT_W-1:0] o_eport_level,
  output logic                              o_host_if_enable,
  output logic                              o_twowire5_enable
);
  import gpio_def_pkg::*;

  // ********************************************************
  // Declarations
  // ********************************************************
  logic [DPORT_W-1:0] dport_direction_q;
  logic [DPORT_W-1:0] dport_output_data_q;
  logic [EPORT_W-1:0] eport_direction_q;
  logic [EPORT_W-1:0] eport_output_data_q;
  logic [FPORT_W-1:0] fport_direction_q;
  logic [FPORT_W-1:0] fport_output_data_q;
  logic [CTRL_W-1:0]  host_ctrl_q;
  logic [DPORT_W-1:0] dsync1_q, dsync2_q;
  logic [EPORT_W-1:0] esync1_q, esync2_q;
  logic [FPORT_W-1:0] fsync1_q, fsync2_q;
  logic               host_en;
  logic               wr_go;
  logic [DPORT_W-1:0] d_own, d_poe, d_pout, d_oe_d, d_out_d;
  logic [EPORT_W-1:0] e_own, e_poe, e_pout, e_oe_d, e_out_d;
  logic [PULL_W-1:0]  pull_d;
  logic [DATA_W-1:0]  rdata_d;
  logic [7:0]         wbyte;

  // Pick the peripheral bit where it owns the pin, else the port bit
  function automatic logic [7:0] own_mux(input logic [7:0] own,
                                         input logic [7:0] periph,
                                         input logic [7:0] port);
    own_mux = (own & periph) | (~own & port);
  endfunction

  // Widen a byte into a bus word with zeros above
  function automatic logic [DATA_W-1:0] to_word(input logic [7:0] b);
    to_word = {{(DATA_W-8){1'b0}}, b};
  endfunction

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  // Two stages; only the second stage is ever read by logic
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dsync1_q <= DPORT_RST;
      dsync2_q <= DPORT_RST;
      esync1_q <= EPORT_RST;
      esync2_q <= EPORT_RST;
      fsync1_q <= FPORT_RST;
      fsync2_q <= FPORT_RST;
    end else begin
      dsync1_q <= i_dport_pin;
      dsync2_q <= dsync1_q;
      esync1_q <= i_eport_pin;
      esync2_q <= esync1_q;
      fsync1_q <= i_fport_pin;
      fsync2_q <= fsync1_q;
    end
  end

  // ********************************************************
  // Avalon-MM handshake
  // ********************************************************
  // One wait state per access keeps read data registered
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_waitrequest <= 1'b1;
    end else begin
      o_waitrequest <= ~((i_read | i_write) & o_waitrequest);
    end
  end

  assign wr_go = i_write & ~o_waitrequest & i_byteenable[0];
  assign wbyte = i_writedata[7:0];

  // Read mux; pin-state locations return synchronised levels
  always_comb begin
    rdata_d = RDATA_ZERO;
    unique case (i_address)
      OFS_DPORT_PIN_DIR:  rdata_d = to_word(dsync2_q);
      OFS_DPORT_OUT_DATA: rdata_d = to_word(dport_output_data_q);
      OFS_EPORT_PIN_DIR:  rdata_d = to_word(esync2_q);
      OFS_EPORT_OUT_DATA: rdata_d = to_word(eport_output_data_q);
      OFS_FPORT_PIN_DIR:  rdata_d = to_word({4'h0, fsync2_q});
      OFS_FPORT_OUT_DATA: rdata_d = to_word({4'h0, fport_output_data_q});
      OFS_HOST_IF_CTRL:   rdata_d = {{(DATA_W-CTRL_W){1'b0}}, host_ctrl_q};
      OFS_PULLUP_STATE:   rdata_d = to_word({2'h0, o_dport_pullup});
      default:            rdata_d = RDATA_ZERO;
    endcase
  end

  // Read data is captured while waitrequest is still high
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_readdata <= RDATA_ZERO;
    end else if (i_read & o_waitrequest) begin
      o_readdata <= rdata_d;
    end
  end

  // ********************************************************
  // Port D and E registers and host control
  // ********************************************************
  // Cleared by system reset and by the watchdog reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dport_direction_q   <= DPORT_RST;
      dport_output_data_q <= DPORT_RST;
      eport_direction_q   <= EPORT_RST;
      eport_output_data_q <= EPORT_RST;
      host_ctrl_q         <= CTRL_RST;
    end else if (i_wdt_rst) begin
      dport_direction_q   <= DPORT_RST;
      dport_output_data_q <= DPORT_RST;
      eport_direction_q   <= EPORT_RST;
      eport_output_data_q <= EPORT_RST;
      host_ctrl_q         <= CTRL_RST;
    end else if (wr_go) begin
      unique case (i_address)
        OFS_DPORT_PIN_DIR:  dport_direction_q   <= wbyte;
        OFS_DPORT_OUT_DATA: dport_output_data_q <= wbyte;
        OFS_EPORT_PIN_DIR:  eport_direction_q   <= wbyte;
        OFS_EPORT_OUT_DATA: eport_output_data_q <= wbyte;
        OFS_HOST_IF_CTRL: begin
          if (i_byteenable[1]) begin
            host_ctrl_q <= i_writedata[CTRL_W-1:0];
          end else begin
            host_ctrl_q <= {host_ctrl_q[CTRL_W-1], wbyte};
          end
        end
        default: ;
      endcase
    end
  end

  // ********************************************************
  // Port F registers
  // ********************************************************
  // Watchdog reset is ignored here so port F keeps driving
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fport_direction_q   <= FPORT_RST;
      fport_output_data_q <= FPORT_RST;
    end else if (wr_go && i_address == OFS_FPORT_PIN_DIR) begin
      fport_direction_q   <= wbyte[FPORT_W-1:0];
    end else if (wr_go && i_address == OFS_FPORT_OUT_DATA) begin
      fport_output_data_q <= wbyte[FPORT_W-1:0];
    end
  end

  // ********************************************************
  // Pin ownership
  // ********************************************************
  // Any one channel or the serial FIFO keeps the host interface up
  assign host_en = host_ctrl_q[CB_CH1] | host_ctrl_q[CB_CH2]
                 | host_ctrl_q[CB_CH3] | host_ctrl_q[CB_SFIFO];

  // Port D: pins 7-6 share the two-wire owner, pins 5-4 the host interface, pins 3-0 one owner each
  always_comb begin
    d_own = {host_ctrl_q[CB_TW5], host_ctrl_q[CB_TW5], host_en, host_en,
             host_ctrl_q[CB_A20], host_ctrl_q[CB_PME], host_ctrl_q[CB_SMI],
             host_ctrl_q[CB_SCI]};
    d_poe  = 8'h00;
    d_pout = 8'h00;
    d_poe[DP_TW_DATA]  = i_tw5_data_oe;
    d_pout[DP_TW_DATA] = i_tw5_data_out;
    d_poe[DP_TW_CLK]   = i_tw5_clk_oe;
    d_pout[DP_TW_CLK]  = i_tw5_clk_out;
    d_poe[DP_PWRDN]    = 1'b0;
    d_poe[DP_CLOCK_RUN_LINE]   = i_clock_run_oe;
    d_pout[DP_CLOCK_RUN_LINE]  = i_clock_run_out;
    d_poe[DP_A20]      = 1'b1;
    d_pout[DP_A20]     = i_gate_a20_out;
    d_poe[DP_PME]      = 1'b1;
    d_pout[DP_PME]     = i_power_event_out;
    d_poe[DP_SMI]      = 1'b1;
    d_pout[DP_SMI]     = i_sys_mgmt_irq_out;
    d_poe[DP_SCI]      = 1'b1;
    d_pout[DP_SCI]     = i_ctrl_irq_out;
    d_oe_d  = own_mux(d_own, d_poe, dport_direction_q);
    d_out_d = own_mux(d_own, d_pout, dport_output_data_q);
  end

  // Port E: whole port follows the host interface
  always_comb begin
    e_own  = {EPORT_W{host_en}};
    e_poe  = 8'h00;
    e_pout = 8'h00;
    e_poe[EP_SERIRQ]  = i_serirq_oe;
    e_pout[EP_SERIRQ] = i_serirq_out;
    e_poe[EP_LAD_HI:0]  = i_lad_oe;
    e_pout[EP_LAD_HI:0] = i_lad_out;
    e_oe_d  = own_mux(e_own, e_poe, eport_direction_q);
    e_out_d = own_mux(e_own, e_pout, eport_output_data_q);
  end

  // ********************************************************
  // Pad registers
  // ********************************************************
  // Registered pads add one cycle but keep outputs glitch-free
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dport_oe  <= DPORT_RST;
      o_dport_out <= DPORT_RST;
      o_eport_oe  <= EPORT_RST;
      o_eport_out <= EPORT_RST;
      o_fport_oe  <= FPORT_RST;
      o_fport_out <= FPORT_RST;
    end else begin
      o_dport_oe  <= d_oe_d;
      o_dport_out <= d_out_d;
      o_eport_oe  <= e_oe_d;
      o_eport_out <= e_out_d;
      o_fport_oe  <= fport_direction_q;
      o_fport_out <= fport_output_data_q;
    end
  end

  // Levels and enables handed to the peripheral units
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dport_level     <= DPORT_RST;
      o_eport_level     <= EPORT_RST;
      o_host_if_enable  <= 1'b0;
      o_twowire5_enable <= 1'b0;
    end else begin
      o_dport_level     <= dsync2_q;
      o_eport_level     <= esync2_q;
      o_host_if_enable  <= host_en;
      o_twowire5_enable <= host_ctrl_q[CB_TW5];
    end
  end

  // ********************************************************
  // Port D pull-ups
  // ********************************************************
  // Pull-up only on an input pin whose data bit is 1
  assign pull_d = ~dport_direction_q[PULL_W-1:0]
                & dport_output_data_q[PULL_W-1:0];

  // Software standby freezes the last state; hardware standby kills it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dport_pullup <= PULL_RST;
    end else if (i_hw_standby || i_wdt_rst) begin
      o_dport_pullup <= PULL_RST;
    end else if (!i_sw_standby) begin
      o_dport_pullup <= pull_d;
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence bus_req_s;
    (i_read | i_write) && o_waitrequest;
  endsequence

  sequence bus_done_s;
    ##1 !o_waitrequest ##1 o_waitrequest;
  endsequence

  bus_handshake_a: assert property (bus_req_s |-> bus_done_s)
    else $error("Bus access not answered in one wait state");

  host_enable_a: assert property (o_host_if_enable == $past(host_en)
    && (host_en == (host_ctrl_q[CB_SFIFO:CB_CH1] != 4'h0)))
    else $error("Host enable does not follow the four enables");

  twowire_pin_a: assert property ($past(host_ctrl_q[CB_TW5])
    |-> o_dport_oe[DP_TW_DATA] == $past(i_tw5_data_oe))
    else $error("Two-wire unit does not own its data pin");

  pwrdn_input_a: assert property ($past(host_en)
    |-> !o_dport_oe[DP_PWRDN] && o_eport_oe[EP_LCLK:EP_FRAME] == 3'h0)
    else $error("Host input pin is driven");

  a20_drive_a: assert property ($past(host_ctrl_q[CB_A20])
    |-> o_dport_oe[DP_A20] && o_dport_out[DP_A20] == $past(i_gate_a20_out))
    else $error("Gate A20 pin not driven from its source");

  gpio_dir_a: assert property (!$past(host_en)
    |-> o_eport_oe == $past(eport_direction_q))
    else $error("Port E direction not applied to the pads");

  lad_drive_a: assert property ($past(host_en)
    |-> o_eport_out[EP_LAD_HI:0] == $past(i_lad_out))
    else $error("Address-data lines not driven by the host unit");

  pullup_rule_a: assert property (!$past(i_hw_standby) && !$past(i_sw_standby)
    && !$past(i_wdt_rst) |-> o_dport_pullup == $past(pull_d))
    else $error("Pull-up state does not match direction and data");

  pullup_off_a: assert property (i_hw_standby |=> o_dport_pullup == PULL_RST)
    else $error("Pull-ups not off in hardware standby");

  pullup_hold_a: assert property (i_sw_standby && !i_hw_standby && !i_wdt_rst
    |=> $stable(o_dport_pullup))
    else $error("Pull-ups changed during software standby");

  fport_keep_a: assert property (i_wdt_rst && !wr_go
    |=> $stable(fport_direction_q) && $stable(fport_output_data_q))
    else $error("Port F lost its contents on watchdog reset");

  pin_read_a: assert property (i_read && o_waitrequest
    && i_address == OFS_DPORT_PIN_DIR
    |=> o_readdata == to_word($past(dsync2_q)))
    else $error("Port D pin read does not return pin levels");

  sync_delay_a: assert property (##2 esync2_q == $past(i_eport_pin, 2))
    else $error("Pin synchroniser is not two stages");

endmodule

`default_nettype wire

/* File: tb/gpio_ports_d_e_f_pin_mux_test.sv */
/*
 * Self-checking bench for the port D/E/F block over Avalon-MM.
 * Assumes pads follow their cause one edge later; bus waits are not counted.
 */
`timescale 1ns/10ps
`default_nettype none
module gpio_ports_d_e_f_pin_mux_test;
  import gpio_def_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wdt_rst = 1'b0;
  logic i_hw_standby = 1'b0, i_sw_standby = 1'b0;
  logic [ADDR_W-1:0] i_address = 5'h00;
  logic i_read = 1'b0, i_write = 1'b0;
  logic [DATA_W-1:0] i_writedata = 32'h0, o_readdata, q, r;
  logic [BE_W-1:0] i_byteenable = 4'h3;
  logic o_waitrequest, o_host_if_enable, o_twowire5_enable;
  logic [7:0] i_dport_pin, i_eport_pin, o_dport_out, o_dport_oe, o_eport_out, o_eport_oe;
  logic [7:0] o_dport_level, o_eport_level;
  logic [3:0] i_fport_pin, o_fport_out, o_fport_oe;
  logic [5:0] o_dport_pullup;
  logic [19:0] ext = 20'h0, pv = 20'h0;
  logic [31:0] rnd = 32'h0000_005F;
  int miscompares = 0, comparisons = 0, cyc = 0;
  always #25 i_clk = ~i_clk;
  // Peripheral requests come from pv, pad levels from the partner
  gpio_def_port gpio_def_port_i (.i_clk(i_clk), .i_rst(i_rst), .i_wdt_rst(i_wdt_rst),
    .i_hw_standby(i_hw_standby), .i_sw_standby(i_sw_standby), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_dport_pin(i_dport_pin), .i_eport_pin(i_eport_pin), .i_fport_pin(i_fport_pin),
    .o_dport_out(o_dport_out), .o_dport_oe(o_dport_oe), .o_dport_pullup(o_dport_pullup),
    .o_eport_out(o_eport_out), .o_eport_oe(o_eport_oe), .o_fport_out(o_fport_out),
    .o_fport_oe(o_fport_oe), .i_tw5_data_oe(pv[0]), .i_tw5_data_out(pv[1]),
    .i_tw5_clk_oe(pv[2]), .i_tw5_clk_out(pv[3]), .i_clock_run_oe(pv[4]),
    .i_clock_run_out(pv[5]), .i_gate_a20_out(pv[6]), .i_power_event_out(pv[7]),
    .i_sys_mgmt_irq_out(pv[8]), .i_ctrl_irq_out(pv[9]), .i_serirq_oe(pv[10]),
    .i_serirq_out(pv[11]), .i_lad_oe(pv[15:12]), .i_lad_out(pv[19:16]),
    .o_dport_level(o_dport_level), .o_eport_level(o_eport_level),
    .o_host_if_enable(o_host_if_enable),
    .o_twowire5_enable(o_twowire5_enable));
  pin_partner pin_partner_i (.i_d_oe(o_dport_oe), .i_d_out(o_dport_out),
    .i_e_oe(o_eport_oe), .i_e_out(o_eport_out), .i_f_oe(o_fport_oe),
    .i_f_out(o_fport_out), .i_ext(ext), .o_d(i_dport_pin), .o_e(i_eport_pin),
    .o_f(i_fport_pin));
  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ********************************************************
  // Bus cycles: hold the request until waitrequest is seen low
  // ********************************************************
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_address <= a;
    i_write <= w;
    i_read <= ~w;
    i_writedata <= d;
    // Only the hang guard ends a wait that never finishes
    do begin
      @(posedge i_clk);
    end while (o_waitrequest !== 1'b0);
    q = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h0);
    check(name, q, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    idle(5);
    i_rst <= 1'b0;
    rdc(OFS_DPORT_OUT_DATA, 32'h0, "dport data");
    rdc(OFS_EPORT_OUT_DATA, 32'h0, "eport data");
    rdc(OFS_FPORT_OUT_DATA, 32'h0, "fport data");
    check("enables", 32'({o_dport_oe, o_eport_oe, o_fport_oe}), 32'h0);
    check("pullups", 32'(o_dport_pullup), 32'h0);
    // Live levels need the synchroniser to settle before a read
    r = xs();
    ext <= r[19:0];
    idle(5);
    check("dport level", 32'(o_dport_level), 32'(ext[7:0]));
    check("eport level", 32'(o_eport_level), 32'(ext[15:8]));
    rdc(OFS_DPORT_PIN_DIR, 32'(ext[7:0]), "dport pins");
    rdc(OFS_EPORT_PIN_DIR, 32'(ext[15:8]), "eport pins");
    rdc(OFS_FPORT_PIN_DIR, 32'(ext[19:16]), "fport pins");
    for (int k = 0; k < 3; k++) begin
      r = xs();
      wr(OFS_DPORT_OUT_DATA, 32'(r[7:0]));
      wr(OFS_DPORT_PIN_DIR, 32'(r[15:8]));
      idle(2);
      check("dport oe", 32'(o_dport_oe), 32'(r[15:8]));
      check("dport out", 32'(o_dport_out & r[15:8]), 32'(r[7:0] & r[15:8]));
      check("pullup", 32'(o_dport_pullup), 32'(~r[13:8] & r[5:0]));
      rdc(OFS_DPORT_OUT_DATA, 32'(r[7:0]), "dport data");
    end
    // Standby: software keeps pull-ups, hardware forces them off
    wr(OFS_DPORT_OUT_DATA, 32'h3F);
    wr(OFS_DPORT_PIN_DIR, 32'h0);
    // Let the pull-ups settle before standby freezes them
    idle(2);
    check("pullup on", 32'(o_dport_pullup), 32'h3F);
    i_sw_standby <= 1'b1;
    wr(OFS_DPORT_PIN_DIR, 32'hFF);
    idle(2);
    check("held pullup", 32'(o_dport_pullup), 32'h3F);
    i_sw_standby <= 1'b0;
    wr(OFS_DPORT_PIN_DIR, 32'h0);
    i_hw_standby <= 1'b1;
    idle(2);
    check("standby pullup", 32'(o_dport_pullup), 32'h0);
    i_hw_standby <= 1'b0;
    idle(2);
    check("pullup back", 32'(o_dport_pullup), 32'h3F);
    r = xs();
    wr(OFS_EPORT_OUT_DATA, 32'(r[7:0]));
    wr(OFS_EPORT_PIN_DIR, 32'hFF);
    idle(2);
    check("eport oe", 32'(o_eport_oe), 32'hFF);
    check("eport out", 32'(o_eport_out), 32'(r[7:0]));
    rdc(OFS_EPORT_OUT_DATA, 32'(r[7:0]), "eport data");
    // Any one of the four enables turns the host interface on
    for (int k = 0; k < 4; k++) begin
      wr(OFS_HOST_IF_CTRL, 32'h1 << k);
      idle(2);
      check("host on", 32'(o_host_if_enable), 32'h1);
    end
    wr(OFS_HOST_IF_CTRL, 32'h0);
    idle(2);
    check("host off", 32'(o_host_if_enable), 32'h0);
    // Every shared function at once, port bits set to disagree
    r = xs();
    pv <= r[19:0];
    wr(OFS_HOST_IF_CTRL, 32'h1F1);
    idle(2);
    check("eport owned oe", 32'(o_eport_oe), 32'({pv[10], 3'h0, pv[15:12]}));
    check("lad out", 32'(o_eport_out[3:0]), 32'(pv[19:16]));
    check("dport owned oe", 32'(o_dport_oe), 32'({pv[0], pv[2], 1'b0, pv[4], 4'hF}));
    check("dport owned out", 32'(o_dport_out[3:0]), 32'({pv[6], pv[7], pv[8], pv[9]}));
    check("dport owned hi", 32'(o_dport_out[7:4]), 32'({pv[1], pv[3], 1'b0, pv[5]}));
    check("eport owned hi", 32'(o_eport_out[7:4]), 32'({pv[11], 3'h0}));
    check("twowire on", 32'(o_twowire5_enable), 32'h1);
    // Watchdog reset clears D/E state but port F survives
    wr(OFS_FPORT_PIN_DIR, 32'hA);
    wr(OFS_FPORT_OUT_DATA, 32'h5);
    i_wdt_rst <= 1'b1;
    idle(1);
    i_wdt_rst <= 1'b0;
    idle(2);
    check("fport oe", 32'(o_fport_oe), 32'hA);
    check("fport out", 32'(o_fport_out), 32'h5);
    check("eport oe cleared", 32'(o_eport_oe), 32'h0);
    rdc(OFS_FPORT_OUT_DATA, 32'h5, "fport data");
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: tb/pin_partner.sv */
/*
 * Behavioural pads and external drivers for ports D, E and F.
 * Assumes the outside world drives every pin strongly, so a pull-up
 * never decides a level; a pad driven by the block shows its data.
 */
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
  // Block drive
  input  wire logic [7:0]  i_d_oe,
  input  wire logic [7:0]  i_d_out,
  input  wire logic [7:0]  i_e_oe,
  input  wire logic [7:0]  i_e_out,
  input  wire logic [3:0]  i_f_oe,
  input  wire logic [3:0]  i_f_out,
  // Outside levels, F in [19:16], E in [15:8], D in [7:0]
  input  wire logic [19:0] i_ext,
  // Resolved pad levels
  output logic      [7:0]  o_d,
  output logic      [7:0]  o_e,
  output logic      [3:0]  o_f
);
  // Block wins where it drives; the outside only where it is released
  assign o_d = (i_d_oe & i_d_out) | (~i_d_oe & i_ext[7:0]);
  assign o_e = (i_e_oe & i_e_out) | (~i_e_oe & i_ext[15:8]);
  assign o_f = (i_f_oe & i_f_out) | (~i_f_oe & i_ext[19:16]);
endmodule
`default_nettype wire
